// ---- verilog/nvpi_pkg.sv ----
// Package of constants and types for the native video pixel input.
package nvpi_pkg;
  // ---------------------------------------------------------------
  // Pixel word layout
  // ---------------------------------------------------------------
  localparam int PIXEL_W = 48;
  localparam int SLOT_HI_TOP = 47;
  localparam int SLOT_MID_TOP = 31;
  localparam int SLOT_LO_TOP = 15;
  localparam int SLOT_W = 16;
  localparam int MAX_PPC = 4;
  localparam int LINE_CNT_W = 16;
  localparam int PIX_CNT_W = 16;
  // ---------------------------------------------------------------
  // Sampling formats
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {NVPI_RGB, NVPI_YCC444, NVPI_YCC422, NVPI_YONLY} nvpi_fmt_e;
  // Reset values
  localparam logic [15:0] LINE_RST = 16'h0000;
  localparam logic [15:0] PIX_RST = 16'h0000;
endpackage

// ---- verilog/nvpi_if.sv ----
// Interface carrying the native video timing and pixel lines.
`timescale 1ns/1ps
interface nvpi_if #(parameter int PPC = 4);
  logic vsync; // Vertical sync, high during pulse
  logic hsync; // Horizontal sync, high during pulse
  logic de; // Data valid, high for active pixels
  logic [PPC*48-1:0] pixels; // Pixel words, pixel 0 lowest
  modport source (output vsync, output hsync, output de, output pixels);
  modport sink (input vsync, input hsync, input de, input pixels);
endinterface

// ---- verilog/nvpi_source.sv ----
// Source end: user video timing generator driving the native port.
`timescale 1ns/1ps
module nvpi_source
  import nvpi_pkg::*;
#(
  parameter int PPC = 4,
  parameter int H_ACTIVE = 8,
  parameter int H_FP = 2,
  parameter int H_SYNC = 2,
  parameter int H_BP = 2,
  parameter int V_ACTIVE = 4,
  parameter int V_FP = 1,
  parameter int V_SYNC = 1,
  parameter int V_BP = 1
)
(
  input wire logic mclk, // Video clock
  input wire logic reset, // Synchronous reset, active high
  input wire logic run, // Start producing frames
  input wire logic s_valid, // User pixel group offered
  input wire logic [PPC*48-1:0] s_pixels, // User pixel group
  output logic s_ready, // Group taken this cycle
  nvpi_if.source vid // Native video port
);
  // ---------------------------------------------------------------
  // Timing state
  // ---------------------------------------------------------------
  localparam int HTOT = (H_ACTIVE + PPC - 1) / PPC + H_FP + H_SYNC + H_BP;
  localparam int VTOT = V_ACTIVE + V_FP + V_SYNC + V_BP;
  typedef struct packed {
    logic [15:0] hc;
    logic [15:0] vc;
    logic on;
    logic vs;
    logic hs;
    logic de;
    logic [PPC*48-1:0] pix;
  } nvpi_src_s;
  nvpi_src_s q;
  nvpi_src_s next_q;
  logic act_h;
  logic act_v;
  localparam logic [15:0] HTOT_M1 = 16'(HTOT - 1);
  localparam logic [15:0] VTOT_M1 = 16'(VTOT - 1);
  // Active window: sync, back porch, active, front porch order
  assign act_h = q.hc >= 16'(H_SYNC + H_BP) && q.hc < 16'(HTOT - H_FP);
  assign act_v = q.vc >= 16'(V_SYNC + V_BP) && q.vc < 16'(VTOT - V_FP);
  // DE held for the whole active run, no mid-line gaps
  assign s_ready = q.on && act_h && act_v;
  // Counters and line levels; pixels stall-free, user must keep up
  always_comb
  begin
    next_q = q;
    next_q.on = q.on | run;
    if (q.on)
    begin
      next_q.hc = (q.hc == HTOT_M1) ? 16'h0000 : q.hc + 16'h0001;
      if (q.hc == HTOT_M1)
        next_q.vc = (q.vc == VTOT_M1) ? 16'h0000 : q.vc + 16'h0001;
    end
    next_q.vs = q.on && q.vc < 16'(V_SYNC); // Frame boundary
    next_q.hs = q.on && q.hc < 16'(H_SYNC); // Line advance
    next_q.de = s_ready;
    // Missing user data becomes zero pixels, padding a short tail
    next_q.pix = (s_ready && s_valid) ? s_pixels : '0;
  end
  // State register
  always_ff @(posedge mclk)
  begin
    if (reset)
      q <= '0;
    else
      q <= next_q;
  end
  assign vid.vsync = q.vs;
  assign vid.hsync = q.hs;
  assign vid.de = q.de;
  assign vid.pixels = q.pix;
endmodule

// ---- verilog/nvpi_sink.sv ----
// Device end: native video input capture with two-entry output buffer.
`timescale 1ns/1ps
module nvpi_sink
  import nvpi_pkg::*;
#(
  parameter int PPC = 4
)
(
  input wire logic mclk, // Video clock
  input wire logic reset, // Synchronous reset, active high
  input wire nvpi_fmt_e fmt, // Sampling format, static
  nvpi_if.sink vid, // Native video port
  output logic m_valid, // Output group available
  input wire logic m_ready, // Receiver takes group
  output logic [PPC*48-1:0] m_data, // Stream-order pixels
  output logic m_sof, // Group is first of frame
  output logic m_eol, // Group is last of line
  output logic [PPC-1:0] m_is_cr, // 422 chroma of pixel is Cr
  output logic [LINE_CNT_W-1:0] line_count, // Lines since frame start
  output logic overflow // Word lost while buffer full
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  localparam int EW = PPC*48 + 2 + PPC;
  typedef struct packed {
    logic vs;
    logic hs;
    logic de;
    logic [PPC*48-1:0] pix;
    logic sof_pend;
    logic chroma_cr;
    logic [LINE_CNT_W-1:0] lines;
    logic held;
    logic [EW-1:0] hold_w;
    logic [1:0] cnt;
    logic [EW-1:0] b0;
    logic [EW-1:0] b1;
    logic ovf;
  } nvpi_snk_s;
  nvpi_snk_s q;
  nvpi_snk_s next_q;
  // ---------------------------------------------------------------
  // Remap native word into stream slot order
  // ---------------------------------------------------------------
  logic [PPC*48-1:0] remap;
  logic [PPC-1:0] cr_flags;
  genvar g;
  generate
    for (g = 0; g < PPC; g++)
    begin : g_pix
      logic [47:0] w;
      logic [15:0] top;
      logic [15:0] mid;
      logic [15:0] low;
      assign w = q.pix[g*48 +: 48];
      // Left-aligned slots at 47, 31 and 15
      assign top = w[SLOT_HI_TOP -: SLOT_W];
      assign mid = w[SLOT_MID_TOP -: SLOT_W];
      assign low = w[SLOT_LO_TOP -: SLOT_W];
      // Comp1 low, comp2 middle, comp3 high; Y-only luma sits in top
      assign remap[g*48 +: 48] = (fmt == NVPI_YCC422) ? {16'h0000, top, mid} :
                                 (fmt == NVPI_YONLY) ? {32'h0000_0000, top} :
                                 {top, low, mid};
      // Cb on even pixels of a line, Cr on odd
      assign cr_flags[g] = (fmt == NVPI_YCC422) && ((g % 2 == 1) ^ q.chroma_cr);
    end
  endgenerate
  // ---------------------------------------------------------------
  // Capture and buffer
  // ---------------------------------------------------------------
  logic vs_fall;
  logic hs_rise;
  logic cap;
  logic push;
  logic pop;
  logic [EW-1:0] word;
  assign vs_fall = q.vs && !vid.vsync;
  assign hs_rise = !q.hs && vid.hsync;
  // Hold a captured group one cycle to learn its end-of-line mark
  assign cap = q.de;
  assign push = q.held;
  assign pop = m_valid && m_ready;
  assign word = q.hold_w;
  always_comb
  begin
    next_q = q;
    // Inputs registered on the rising clock
    next_q.vs = vid.vsync;
    next_q.hs = vid.hsync;
    next_q.de = vid.de;
    next_q.pix = vid.pixels;
    // Counter wraps silently; taller frames alias
    if (hs_rise)
      next_q.lines = q.lines + LINE_CNT_W'(1);
    // Two entries cover one stall cycle per line; longer stalls drop words
    // Buffer pop then push
    if (pop)
    begin
      next_q.b0 = q.b1;
      next_q.cnt = q.cnt - 2'd1;
    end
    next_q.held = cap; // Valid-gated capture only
    if (cap)
    begin
      next_q.hold_w = {remap, q.sof_pend, 1'b0, cr_flags};
      next_q.sof_pend = 1'b0;
      if (PPC % 2 == 1)
        next_q.chroma_cr = !q.chroma_cr;
    end
    // Chroma phase restarts per line, not per valid gap,
    // so a toggling valid keeps Cb and Cr alternating
    if (hs_rise)
      next_q.chroma_cr = 1'b0;
    if (q.held)
      next_q.hold_w[PPC] = !q.de; // End of line when valid dropped
    if (push)
    begin
      if (next_q.cnt == 2'd2)
        next_q.ovf = 1'b1; // Sticky until next frame
      else if (next_q.cnt == 2'd1)
      begin
        next_q.b1 = q.held ? {word[EW-1:PPC+1], !q.de, word[PPC-1:0]} : word;
        next_q.cnt = 2'd2;
      end
      else
      begin
        next_q.b0 = {word[EW-1:PPC+1], !q.de, word[PPC-1:0]};
        next_q.cnt = 2'd1;
      end
    end
    // Frame restart on vsync trailing edge clears datapath
    if (vs_fall)
    begin
      next_q.lines = LINE_RST;
      next_q.sof_pend = 1'b1;
      next_q.chroma_cr = 1'b0;
      next_q.held = 1'b0;
      next_q.cnt = 2'd0;
      next_q.ovf = 1'b0;
    end
  end
  // State register
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      q <= '0;
      q.sof_pend <= 1'b1;
    end
    else
      q <= next_q;
  end
  assign m_valid = q.cnt != 2'd0;
  assign m_data = q.b0[EW-1 -: PPC*48];
  assign m_sof = q.b0[PPC+1];
  assign m_eol = q.b0[PPC];
  assign m_is_cr = q.b0[PPC-1:0];
  assign line_count = q.lines;
  assign overflow = q.ovf;
endmodule

// ---- verification/nvpi_properties.sv ----
// Assertions on the native video port lines driven by the source end.
`timescale 1ns/1ps
module nvpi_properties #(
  parameter int PPC = 1,
  parameter int V_ACTIVE = 4
)
(
  input wire logic mclk, // Video clock
  input wire logic reset, // Sync reset
  input wire logic vsync, // Vertical sync
  input wire logic hsync, // Horizontal sync
  input wire logic de, // Data valid
  input wire logic [PPC*48-1:0] pixels // Pixel words
);
  // ---------------------
  // Port timing checks
  // ---------------------
  logic [7:0] lines;
  logic seen;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  // Active lines per frame; the first frame after reset is not trusted
  always_ff @(posedge mclk)
  begin
    if (reset || vsync)
      lines <= 8'h00;
    else if ($rose(de))
      lines <= lines + 8'h01;
    seen <= !reset && (seen || vsync);
  end
  hsync_width_a: assert property ($rose(hsync) |-> hsync[*2] ##1 !hsync)
    else $error("hsync width wrong");
  back_porch_a: assert property ($rose(de) |-> $past(hsync, 3) && !$past(hsync, 2))
    else $error("back porch wrong");
  front_porch_a: assert property ($fell(de) |-> !hsync[*2] ##1 hsync)
    else $error("front porch wrong");
  line_period_a: assert property ($rose(hsync) |-> ##14 $rose(hsync))
    else $error("line period wrong");
  de_run_a: assert property ($rose(de) |-> de[*8] ##1 !de)
    else $error("valid run broken");
  sync_no_data_a: assert property (hsync |-> !de)
    else $error("valid during hsync");
  vblank_no_data_a: assert property (vsync |-> !de)
    else $error("valid during vsync");
  active_lines_a: assert property ($rose(vsync) && seen |-> lines == V_ACTIVE)
    else $error("active line count wrong");
  blank_pixels_zero_a: assert property (!de |-> pixels == '0)
    else $error("pixels driven outside valid");
endmodule

// ---- verification/native_video_pixel_input_bench.sv ----
// Testbench joining source and sink ends of the native video port.
`timescale 1ns/1ps
module native_video_pixel_input_bench;
  import nvpi_pkg::*;
  // ---------------------
  // Signals and both ends
  // ---------------------
  logic mclk, reset, run, s_valid, s_ready, m_valid, m_ready, m_sof, m_eol, overflow;
  logic [47:0] s_pixels, m_data;
  logic [0:0] m_is_cr;
  logic [15:0] line_count, lc_base, lc_exp, pix;
  logic vs_q, hs_q, fde, sof_exp, seen, chk_en;
  logic [47:0] src_q[$], snk_q[$];
  nvpi_fmt_e fmt;
  int n_errors, total_checks;
  // One pixel per clock is enough for this short test timing
  nvpi_if #(.PPC(1)) nvpi_if_inst ();
  nvpi_source #(.PPC(1)) nvpi_source_inst (.mclk(mclk), .reset(reset), .run(run),
    .s_valid(s_valid), .s_pixels(s_pixels), .s_ready(s_ready), .vid(nvpi_if_inst.source));
  nvpi_sink #(.PPC(1)) nvpi_sink_inst (.mclk(mclk), .reset(reset), .fmt(fmt),
    .vid(nvpi_if_inst.sink), .m_valid(m_valid), .m_ready(m_ready), .m_data(m_data),
    .m_sof(m_sof), .m_eol(m_eol), .m_is_cr(m_is_cr), .line_count(line_count),
    .overflow(overflow));
  nvpi_properties #(.PPC(1)) nvpi_properties_inst (.mclk(mclk), .reset(reset),
    .vsync(nvpi_if_inst.vsync), .hsync(nvpi_if_inst.hsync), .de(nvpi_if_inst.de),
    .pixels(nvpi_if_inst.pixels));
  // Stream order of one native pixel
  function automatic logic [47:0] remap(nvpi_fmt_e f, logic [47:0] p);
    case (f)
      NVPI_YCC422: remap = {16'h0000, p[47:32], p[31:16]};
      NVPI_YONLY: remap = {32'h0000_0000, p[47:32]};
      default: remap = {p[47:32], p[15:0], p[31:16]};
    endcase
  endfunction
  // Unused low bits driven to zero
  function automatic logic [47:0] mask(nvpi_fmt_e f, logic [47:0] p);
    if (f == NVPI_YCC422)
      mask = {p[47:16], 16'h0000};
    else if (f == NVPI_YONLY)
      mask = {p[47:32], 32'h0000_0000};
    else
      mask = p;
  endfunction
  task automatic chk_word(logic [47:0] got, logic [47:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %0t word %h not %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(logic got, logic exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %0t flag %b not %b", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Reset held three cycles; timing starts a cycle after release
  task automatic restart(nvpi_fmt_e f);
    @(posedge mclk);
    #1;
    reset = 1'b1;
    run = 1'b0;
    fmt = f;
    repeat (3) @(posedge mclk);
    #1;
    reset = 1'b0;
    @(posedge mclk);
    #1;
    run = 1'b1;
  endtask
  // Clock, 4 ns period
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // Scoreboard on values settled before this edge
  always @(posedge mclk)
  begin
    if (reset)
    begin
      src_q.delete();
      snk_q.delete();
      {seen, fde, sof_exp} = 3'b000;
      pix = 16'h0000;
    end
    else
    begin
      if (s_ready)
        src_q.push_back(s_valid ? s_pixels : 48'h0000_0000_0000);
      if (nvpi_if_inst.de)
      begin
        chk_word(nvpi_if_inst.pixels, src_q.pop_front());
        snk_q.push_back(remap(fmt, nvpi_if_inst.pixels));
      end
      if (m_valid && m_ready && chk_en)
      begin
        chk_word(m_data, snk_q.pop_front());
        chk_flag(m_sof, sof_exp);
        chk_flag(m_eol, pix == 16'h0007);
        chk_flag(m_is_cr[0], fmt == NVPI_YCC422 && pix[0]);
        sof_exp = 1'b0;
        pix = (pix == 16'h0007) ? 16'h0000 : pix + 16'h0001;
      end
      if (vs_q && !nvpi_if_inst.vsync)
        {sof_exp, fde} = 2'b11;
      if (fde && nvpi_if_inst.de)
      begin
        {fde, seen} = 2'b01;
        lc_base = line_count;
        lc_exp = 16'h0000;
      end
      if (!vs_q && nvpi_if_inst.vsync && seen && chk_en)
        chk_flag(line_count - lc_base == lc_exp, 1'b1);
      if (!hs_q && nvpi_if_inst.hsync)
        lc_exp = lc_exp + 16'h0001;
    end
    vs_q = nvpi_if_inst.vsync;
    hs_q = nvpi_if_inst.hsync;
  end
  // Main sequence: every format, then a stalled receiver
  initial
  begin
    void'($urandom(23878));
    {reset, run, m_ready, chk_en, s_valid} = 5'b10110;
    fmt = NVPI_RGB;
    s_pixels = 48'h0000_0000_0000;
    // Traffic forked after seeding so it follows the fixed seed;
    // a gap in s_valid becomes a zero pixel
    fork
      forever
      begin
        @(posedge mclk);
        #1;
        s_valid = ($urandom % 4) != 0;
        s_pixels = mask(fmt, 48'({$urandom, $urandom}));
      end
    join_none
    for (int f = 0; f < 4; f++)
    begin
      restart(nvpi_fmt_e'(f));
      repeat (3) @(posedge nvpi_if_inst.vsync);
      $display("format test %0d done", f);
    end
    chk_en = 1'b0;
    restart(NVPI_RGB);
    m_ready = 1'b0;
    repeat (2) @(posedge nvpi_if_inst.vsync);
    chk_flag(overflow, 1'b1);
    @(negedge nvpi_if_inst.vsync);
    repeat (3) @(posedge mclk);
    #1;
    chk_flag(overflow, 1'b0);
    chk_flag(m_valid, 1'b0);
    $display("stall test done");
    report_and_stop();
  end
  // Hang guard: the run needs about 930 cycles
  initial
  begin
    #40000;
    n_errors++;
    report_and_stop();
  end
endmodule
